// ==== rtl/gpx_pkg.sv ====
// Purpose: Constants for the upper general-purpose port block, ports E to J.
// Assumes: Data-space byte addresses on an 8-bit register port; 20 MHz system clock.
// Notes: Every offset and mask used by the logic is named here, as is the reset value of the software-visible registers.
package gpx_pkg;

    // Data-space addresses of the port registers.
    localparam logic [7:0] ADDR_E_PIN = 8'h2c;
    localparam logic [7:0] ADDR_F_PIN = 8'h2f;
    localparam logic [7:0] ADDR_F_DIR = 8'h30;
    localparam logic [7:0] ADDR_F_OUT = 8'h31;
    localparam logic [7:0] ADDR_G_PIN = 8'h32;
    localparam logic [7:0] ADDR_G_DIR = 8'h33;
    localparam logic [7:0] ADDR_G_OUT = 8'h34;
    localparam logic [7:0] ADDR_H_PIN = 8'hd8;
    localparam logic [7:0] ADDR_H_DIR = 8'hd9;
    localparam logic [7:0] ADDR_H_OUT = 8'hda;
    localparam logic [7:0] ADDR_J_PIN = 8'hdb;
    localparam logic [7:0] ADDR_J_DIR = 8'hdc;
    localparam logic [7:0] ADDR_J_OUT = 8'hdd;
    // Control register that holds the global pull-up disable bit.
    localparam logic [7:0] ADDR_MCU_CTRL = 8'h55;
    localparam int PULLUP_OFF_BIT = 4;

    // Implemented-bit masks; bits outside a mask are read-only zero.
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_G = 8'h1f;
    localparam logic [7:0] MASK_J = 8'h7f;
    localparam logic [7:0] MASK_CTRL = 8'h10;

    // Reset value of every data, direction and control register.
    localparam logic [7:0] RST_VAL = 8'h00;

    // Pin counts per port and their place in the packed synchroniser vector.
    localparam int W_E = 8;
    localparam int W_F = 8;
    localparam int W_G = 5;
    localparam int W_H = 8;
    localparam int W_J = 7;
    localparam int LSB_E = 0;
    localparam int LSB_F = LSB_E + W_E;
    localparam int LSB_G = LSB_F + W_F;
    localparam int LSB_H = LSB_G + W_G;
    localparam int LSB_J = LSB_H + W_H;
    localparam int W_ALL = LSB_J + W_J;

endpackage : gpx_pkg

// ==== rtl/gpx_top.sv ====
// Purpose: Data, direction and pin-level registers for ports E to J.
// Assumes: Register master obeys one-cycle strobes; pins are asynchronous to i_mclk.
// Notes: Read data stand for exactly one cycle after the read strobe, zero otherwise.
`timescale 1ns/1ps

module gpx_top #(
    // One selects the larger package with ports H and J present.
    parameter bit P_HAS_HJ = 1'b1
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Register port.
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Port E pins, input only in this block.
    input wire logic [7:0] i_pe_pin,
    // Port F pins.
    input wire logic [7:0] i_pf_pin,
    output logic [7:0] o_pf_out,
    output logic [7:0] o_pf_oe,
    output logic [7:0] o_pf_pullup,
    // Port G pins.
    input wire logic [4:0] i_pg_pin,
    output logic [4:0] o_pg_out,
    output logic [4:0] o_pg_oe,
    output logic [4:0] o_pg_pullup,
    // Port H pins.
    input wire logic [7:0] i_ph_pin,
    output logic [7:0] o_ph_out,
    output logic [7:0] o_ph_oe,
    output logic [7:0] o_ph_pullup,
    // Port J pins.
    input wire logic [6:0] i_pj_pin,
    output logic [6:0] o_pj_out,
    output logic [6:0] o_pj_oe,
    output logic [6:0] o_pj_pullup
);

    // Merges write data into the implemented bits of a register.
    function automatic logic [7:0] merge_write(input logic [7:0] wdata, input logic [7:0] mask);
        merge_write = wdata & mask;
    endfunction : merge_write

    // True when the optional ports are present in this variant.
    function automatic logic hj_ok(input logic present);
        hj_ok = present;
    endfunction : hj_ok

    // Software-visible registers; the upper bits of masked ones stay zero.
    logic [7:0] pf_out_reg, pf_out_next;
    logic [7:0] pf_dir_reg, pf_dir_next;
    logic [7:0] pg_out_reg, pg_out_next;
    logic [7:0] pg_dir_reg, pg_dir_next;
    logic [7:0] ph_out_reg, ph_out_next;
    logic [7:0] ph_dir_reg, ph_dir_next;
    logic [7:0] pj_out_reg, pj_out_next;
    logic [7:0] pj_dir_reg, pj_dir_next;
    logic [7:0] ctrl_reg, ctrl_next;
    // Pull-up enables, registered so the outputs come straight from flops.
    logic [7:0] pf_pu_reg, pf_pu_next;
    logic [7:0] pg_pu_reg, pg_pu_next;
    logic [7:0] ph_pu_reg, ph_pu_next;
    logic [7:0] pj_pu_reg, pj_pu_next;
    // Read data register.
    logic [7:0] rdata_reg, rdata_next;
    // Two-stage pin synchroniser; only the second stage is read by logic.
    logic [gpx_pkg::W_ALL-1:0] sync1_reg;
    logic [gpx_pkg::W_ALL-1:0] sync2_reg;
    logic [gpx_pkg::W_ALL-1:0] pins_raw;
    // Synchronised pin levels per port, widened to a byte.
    logic [7:0] e_lvl, f_lvl, g_lvl, h_lvl, j_lvl;
    // Global pull-up disable level.
    logic pullup_off;

    assign pins_raw = {i_pj_pin, i_ph_pin, i_pg_pin, i_pf_pin, i_pe_pin};
    assign e_lvl = sync2_reg[gpx_pkg::LSB_E +: gpx_pkg::W_E];
    assign f_lvl = sync2_reg[gpx_pkg::LSB_F +: gpx_pkg::W_F];
    // Bits 5 to 7 of port G and bit 7 of port J have no pin and read zero.
    assign g_lvl = {3'h0, sync2_reg[gpx_pkg::LSB_G +: gpx_pkg::W_G]};
    assign h_lvl = sync2_reg[gpx_pkg::LSB_H +: gpx_pkg::W_H];
    assign j_lvl = {1'h0, sync2_reg[gpx_pkg::LSB_J +: gpx_pkg::W_J]};
    assign pullup_off = ctrl_reg[gpx_pkg::PULLUP_OFF_BIT];

    // Pin synchroniser; the pins are asynchronous, so nothing reads the first stage.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // Next values of the writable registers; pin-level registers ignore writes.
    always_comb begin
        pf_out_next = pf_out_reg;
        pf_dir_next = pf_dir_reg;
        pg_out_next = pg_out_reg;
        pg_dir_next = pg_dir_reg;
        ph_out_next = ph_out_reg;
        ph_dir_next = ph_dir_reg;
        pj_out_next = pj_out_reg;
        pj_dir_next = pj_dir_reg;
        ctrl_next = ctrl_reg;
        if (i_wr) begin
            case (i_addr)
                gpx_pkg::ADDR_F_OUT: begin
                    pf_out_next = merge_write(i_wdata, gpx_pkg::MASK_FULL);
                end
                gpx_pkg::ADDR_F_DIR: begin
                    pf_dir_next = merge_write(i_wdata, gpx_pkg::MASK_FULL);
                end
                gpx_pkg::ADDR_G_OUT: begin
                    pg_out_next = merge_write(i_wdata, gpx_pkg::MASK_G);
                end
                gpx_pkg::ADDR_G_DIR: begin
                    pg_dir_next = merge_write(i_wdata, gpx_pkg::MASK_G);
                end
                gpx_pkg::ADDR_H_OUT: begin
                    // The smaller variant has no port H; the write is dropped.
                    if (hj_ok(P_HAS_HJ)) begin
                        ph_out_next = merge_write(i_wdata, gpx_pkg::MASK_FULL);
                    end
                end
                gpx_pkg::ADDR_H_DIR: begin
                    if (hj_ok(P_HAS_HJ)) begin
                        ph_dir_next = merge_write(i_wdata, gpx_pkg::MASK_FULL);
                    end
                end
                gpx_pkg::ADDR_J_OUT: begin
                    if (hj_ok(P_HAS_HJ)) begin
                        pj_out_next = merge_write(i_wdata, gpx_pkg::MASK_J);
                    end
                end
                gpx_pkg::ADDR_J_DIR: begin
                    if (hj_ok(P_HAS_HJ)) begin
                        pj_dir_next = merge_write(i_wdata, gpx_pkg::MASK_J);
                    end
                end
                gpx_pkg::ADDR_MCU_CTRL: begin
                    ctrl_next = merge_write(i_wdata, gpx_pkg::MASK_CTRL);
                end
                default: begin
                    // Unmapped or read-only address: nothing changes.
                    ctrl_next = ctrl_reg;
                end
            endcase
        end
    end

    // Pull-up enables: input pin, output bit one, and pull-ups not disabled.
    always_comb begin
        pf_pu_next = ~pf_dir_reg & pf_out_reg & {8{~pullup_off}};
        pg_pu_next = ~pg_dir_reg & pg_out_reg & {8{~pullup_off}};
        ph_pu_next = ~ph_dir_reg & ph_out_reg & {8{~pullup_off}};
        pj_pu_next = ~pj_dir_reg & pj_out_reg & {8{~pullup_off}};
    end

    // Read data: valid only in the cycle after the strobe, zero otherwise.
    always_comb begin
        rdata_next = 8'h00;
        if (i_rd) begin
            case (i_addr)
                gpx_pkg::ADDR_E_PIN: rdata_next = e_lvl;
                gpx_pkg::ADDR_F_PIN: rdata_next = f_lvl;
                gpx_pkg::ADDR_F_DIR: rdata_next = pf_dir_reg;
                gpx_pkg::ADDR_F_OUT: rdata_next = pf_out_reg;
                gpx_pkg::ADDR_G_PIN: rdata_next = g_lvl;
                gpx_pkg::ADDR_G_DIR: rdata_next = pg_dir_reg;
                gpx_pkg::ADDR_G_OUT: rdata_next = pg_out_reg;
                gpx_pkg::ADDR_H_PIN: rdata_next = hj_ok(P_HAS_HJ) ? h_lvl : 8'h00;
                gpx_pkg::ADDR_H_DIR: rdata_next = ph_dir_reg;
                gpx_pkg::ADDR_H_OUT: rdata_next = ph_out_reg;
                gpx_pkg::ADDR_J_PIN: rdata_next = hj_ok(P_HAS_HJ) ? j_lvl : 8'h00;
                gpx_pkg::ADDR_J_DIR: rdata_next = pj_dir_reg;
                gpx_pkg::ADDR_J_OUT: rdata_next = pj_out_reg;
                gpx_pkg::ADDR_MCU_CTRL: rdata_next = ctrl_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Register stage for all software state, pull-ups and read data.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pf_out_reg <= gpx_pkg::RST_VAL;
            pf_dir_reg <= gpx_pkg::RST_VAL;
            pg_out_reg <= gpx_pkg::RST_VAL;
            pg_dir_reg <= gpx_pkg::RST_VAL;
            ph_out_reg <= gpx_pkg::RST_VAL;
            ph_dir_reg <= gpx_pkg::RST_VAL;
            pj_out_reg <= gpx_pkg::RST_VAL;
            pj_dir_reg <= gpx_pkg::RST_VAL;
            ctrl_reg <= gpx_pkg::RST_VAL;
            pf_pu_reg <= gpx_pkg::RST_VAL;
            pg_pu_reg <= gpx_pkg::RST_VAL;
            ph_pu_reg <= gpx_pkg::RST_VAL;
            pj_pu_reg <= gpx_pkg::RST_VAL;
            rdata_reg <= gpx_pkg::RST_VAL;
        end else begin
            pf_out_reg <= pf_out_next;
            pf_dir_reg <= pf_dir_next;
            pg_out_reg <= pg_out_next;
            pg_dir_reg <= pg_dir_next;
            ph_out_reg <= ph_out_next;
            ph_dir_reg <= ph_dir_next;
            pj_out_reg <= pj_out_next;
            pj_dir_reg <= pj_dir_next;
            ctrl_reg <= ctrl_next;
            pf_pu_reg <= pf_pu_next;
            pg_pu_reg <= pg_pu_next;
            ph_pu_reg <= ph_pu_next;
            pj_pu_reg <= pj_pu_next;
            rdata_reg <= rdata_next;
        end
    end

    // Pin drive: the output enable is the direction bit, the level the data bit.
    assign o_pf_out = pf_out_reg;
    assign o_pf_oe = pf_dir_reg;
    assign o_pg_out = pg_out_reg[gpx_pkg::W_G-1:0];
    assign o_pg_oe = pg_dir_reg[gpx_pkg::W_G-1:0];
    assign o_ph_out = ph_out_reg;
    assign o_ph_oe = ph_dir_reg;
    assign o_pj_out = pj_out_reg[gpx_pkg::W_J-1:0];
    assign o_pj_oe = pj_dir_reg[gpx_pkg::W_J-1:0];
    assign o_pf_pullup = pf_pu_reg;
    assign o_pg_pullup = pg_pu_reg[gpx_pkg::W_G-1:0];
    assign o_ph_pullup = ph_pu_reg;
    assign o_pj_pullup = pj_pu_reg[gpx_pkg::W_J-1:0];
    assign o_rdata = rdata_reg;

    // Checks on the register and pin behaviour, all in the one clock domain.
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    AST_E_PIN_SYNC: assert property (
        i_rd && i_addr == gpx_pkg::ADDR_E_PIN |=> o_rdata == $past(i_pe_pin, 3))
        else $error("Port E pin read does not match the pins two stages back.");

    AST_F_OUT_WRITE: assert property (
        i_wr && i_addr == gpx_pkg::ADDR_F_OUT |=> o_pf_out == $past(i_wdata))
        else $error("Port F output did not take the written value.");

    AST_F_DIR_READ: assert property (
        i_rd && i_addr == gpx_pkg::ADDR_F_DIR |=> o_rdata == $past(o_pf_oe))
        else $error("Port F direction read does not match the drive enables.");

    AST_G_OUT_MASK: assert property (
        i_rd && i_addr == gpx_pkg::ADDR_G_OUT |=> o_rdata[7:5] == 3'h0)
        else $error("Port G output upper bits did not read zero.");

    AST_G_DIR_WRITE: assert property (
        i_wr && i_addr == gpx_pkg::ADDR_G_DIR |=> o_pg_oe == $past(i_wdata[4:0]))
        else $error("Port G direction did not take the written low bits.");

    AST_G_PIN_UPPER: assert property (
        i_rd && i_addr == gpx_pkg::ADDR_G_PIN |=> o_rdata[7:5] == 3'h0)
        else $error("Port G pin read shows nonzero upper bits.");

    AST_J_DIR_UPPER: assert property (
        i_rd && i_addr == gpx_pkg::ADDR_J_DIR |=> o_rdata[7] == 1'b0)
        else $error("Port J direction bit 7 did not read zero.");

    AST_HJ_ABSENT: assert property (
        !P_HAS_HJ |-> o_ph_oe == 8'h00 && o_pj_oe == 7'h00)
        else $error("Absent ports H or J are driving pins.");

    AST_PULLUP_OFF_KILLS: assert property (
        pullup_off |=> o_pf_pullup == 8'h00 && o_ph_pullup == 8'h00)
        else $error("A pull-up stayed on while pull-ups are disabled.");

    AST_PULLUP_F: assert property (
        1'b1 |=> o_pf_pullup == $past(~o_pf_oe & o_pf_out & {8{~pullup_off}}))
        else $error("Port F pull-up does not follow direction, data and disable.");

    AST_RD_IDLE_ZERO: assert property (
        !i_rd |=> o_rdata == 8'h00)
        else $error("Read data nonzero without a preceding read strobe.");

    AST_H_OUT_WRITE: assert property (
        i_wr && i_addr == gpx_pkg::ADDR_H_OUT && P_HAS_HJ |=> o_ph_out == $past(i_wdata))
        else $error("Port H output did not take the written value.");

    AST_HJ_WRITE_DROP: assert property (
        i_wr && !P_HAS_HJ |=> o_ph_out == 8'h00 && o_pj_out == 7'h00)
        else $error("A write reached ports H or J in the smaller variant.");

    AST_G_PIN_SYNC: assert property (
        i_rd && i_addr == gpx_pkg::ADDR_G_PIN |=> o_rdata[4:0] == $past(i_pg_pin, 3))
        else $error("Port G pin read does not match the pins two stages back.");

    COV_F_WRITE_READ: cover property (
        i_wr && i_addr == gpx_pkg::ADDR_F_OUT ##1 i_rd && i_addr == gpx_pkg::ADDR_F_OUT);
    COV_PULLUP_OFF_SET: cover property (
        i_wr && i_addr == gpx_pkg::ADDR_MCU_CTRL && i_wdata[gpx_pkg::PULLUP_OFF_BIT]);
    COV_G_PIN_READ: cover property (i_rd && i_addr == gpx_pkg::ADDR_G_PIN);
    COV_J_DRIVE: cover property (o_pj_oe != 7'h00);

endmodule : gpx_top

// ==== verification/gpx_pin_model.sv ====
// Purpose: Board-side model of one GPIO port: pad level from drive, pull-up and external source.
// Assumes: Driven by the register block's out, enable and pull-up outputs of one port.
// Notes: A pad with no driver and no pull-up wanders every cycle so a stale level never passes.
`timescale 1ns/1ps

module gpx_pin_model #(
    parameter int W = 8
) (
    // Clock for the floating-pad pattern.
    input wire logic i_clk,
    // Device side of the pad.
    input wire logic [W-1:0] i_out,
    input wire logic [W-1:0] i_oe,
    input wire logic [W-1:0] i_pullup,
    // Board source, used only where its enable is high.
    input wire logic [W-1:0] i_ext,
    input wire logic [W-1:0] i_ext_en,
    // Resolved pad level.
    output logic [W-1:0] o_pin
);
    // Toggling pattern standing in for an undriven, unpulled pad.
    logic [W-1:0] float_reg = '0;

    // Free toggle; the value is deliberately meaningless.
    always @(posedge i_clk) begin
        float_reg <= ~float_reg;
    end

    // Device drive wins, then the board source, then the pull-up, else the pad floats.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (i_oe[i]) begin
                o_pin[i] = i_out[i];
            end else if (i_ext_en[i]) begin
                o_pin[i] = i_ext[i];
            end else if (i_pullup[i]) begin
                o_pin[i] = 1'b1;
            end else begin
                o_pin[i] = float_reg[i];
            end
        end
    end
endmodule : gpx_pin_model

// ==== verification/gpx_top_tb_top.sv ====
// Purpose: Self-checking bench for the port E to J register block.
// Assumes: One-cycle strobes, read data sampled in the cycle after the strobe.
// Notes: Pads are resolved by the board model; port E has no outputs and is driven directly.
`timescale 1ns/1ps

module gpx_top_tb_top;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic i_wr = 1'b0, i_rd = 1'b0;
    logic [7:0] ext = 8'h00, ext_en = 8'hff, ext_e = 8'h00;
    logic [7:0] pf_pin, pf_out, pf_oe, pf_pu, ph_pin, ph_out, ph_oe, ph_pu;
    logic [4:0] pg_pin, pg_out, pg_oe, pg_pu;
    logic [6:0] pj_pin, pj_out, pj_oe, pj_pu;
    // Outputs of the smaller variant that the tests look at.
    logic [7:0] s_rdata, s_ph_oe;
    logic [6:0] s_pj_out;
    int errors = 0;
    int cmp_count = 0;
    // Data and direction registers, with their implemented-bit masks.
    localparam logic [7:0] RW_A [8] = '{gpx_pkg::ADDR_F_DIR, gpx_pkg::ADDR_F_OUT,
        gpx_pkg::ADDR_G_DIR, gpx_pkg::ADDR_G_OUT, gpx_pkg::ADDR_H_DIR, gpx_pkg::ADDR_H_OUT,
        gpx_pkg::ADDR_J_DIR, gpx_pkg::ADDR_J_OUT};
    localparam logic [7:0] RW_M [8] = '{8'hff, 8'hff, 8'h1f, 8'h1f, 8'hff, 8'hff, 8'h7f, 8'h7f};

    // Half-period inversion gives the 50 ns system clock.
    always #25 i_mclk = ~i_mclk;

    gpx_top #(.P_HAS_HJ(1'b1)) DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pe_pin(ext_e),
        .i_pf_pin(pf_pin), .o_pf_out(pf_out), .o_pf_oe(pf_oe), .o_pf_pullup(pf_pu),
        .i_pg_pin(pg_pin), .o_pg_out(pg_out), .o_pg_oe(pg_oe), .o_pg_pullup(pg_pu),
        .i_ph_pin(ph_pin), .o_ph_out(ph_out), .o_ph_oe(ph_oe), .o_ph_pullup(ph_pu),
        .i_pj_pin(pj_pin), .o_pj_out(pj_out), .o_pj_oe(pj_oe), .o_pj_pullup(pj_pu));

    // Smaller variant on the same bus: ports H and J must stay silent and read zero.
    gpx_top #(.P_HAS_HJ(1'b0)) DUT_SMALL (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(s_rdata), .i_pe_pin(ext_e),
        .i_pf_pin(pf_pin), .o_pf_out(), .o_pf_oe(), .o_pf_pullup(),
        .i_pg_pin(pg_pin), .o_pg_out(), .o_pg_oe(), .o_pg_pullup(),
        .i_ph_pin(ph_pin), .o_ph_out(), .o_ph_oe(s_ph_oe), .o_ph_pullup(),
        .i_pj_pin(pj_pin), .o_pj_out(s_pj_out), .o_pj_oe(), .o_pj_pullup());

    // One board model per port with outputs.
    gpx_pin_model #(.W(8)) u_pf (.i_clk(i_mclk), .i_out(pf_out), .i_oe(pf_oe), .i_pullup(pf_pu),
        .i_ext(ext), .i_ext_en(ext_en), .o_pin(pf_pin));
    gpx_pin_model #(.W(5)) u_pg (.i_clk(i_mclk), .i_out(pg_out), .i_oe(pg_oe), .i_pullup(pg_pu),
        .i_ext(ext[4:0]), .i_ext_en(ext_en[4:0]), .o_pin(pg_pin));
    gpx_pin_model #(.W(8)) u_ph (.i_clk(i_mclk), .i_out(ph_out), .i_oe(ph_oe), .i_pullup(ph_pu),
        .i_ext(ext), .i_ext_en(ext_en), .o_pin(ph_pin));
    gpx_pin_model #(.W(7)) u_pj (.i_clk(i_mclk), .i_out(pj_out), .i_oe(pj_oe), .i_pullup(pj_pu),
        .i_ext(ext[6:0]), .i_ext_en(ext_en[6:0]), .o_pin(pj_pin));

    // Counts every comparison and reports any mismatch at once.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One-cycle write strobe; the strobe drops at the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr

    // One-cycle read strobe; data are checked in the single cycle that holds them.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask : rd

    // Prints the totals and the verdict, then stops the run.
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    // Main sequence.
    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        // Every data and direction register comes out of reset cleared, pads released.
        for (int k = 0; k < 8; k++) rd(RW_A[k], 8'h00);
        chk(pf_oe, 8'h00);
        $display("test reset values done");
        // All-ones writes show which bits are implemented; reads return what was kept.
        for (int k = 0; k < 8; k++) wr(RW_A[k], 8'hff);
        for (int k = 0; k < 8; k++) rd(RW_A[k], RW_M[k]);
        chk(s_rdata, 8'h00);
        chk(s_ph_oe, 8'h00);
        chk({1'b0, s_pj_out}, 8'h00);
        chk({3'h0, pg_oe}, 8'h1f);
        chk({3'h0, pg_out}, 8'h1f);
        chk(ph_oe, 8'hff);
        chk({1'b0, pj_out}, 8'h7f);
        wr(gpx_pkg::ADDR_F_PIN, 8'h00);
        wr(8'h40, 8'h55);
        rd(8'h40, 8'h00);
        rd(gpx_pkg::ADDR_F_PIN, 8'hff);
        $display("test register access done");
        // Inputs with the board driving: pads follow the board source.
        for (int k = 0; k < 8; k += 2) wr(RW_A[k], 8'h00);
        ext <= 8'hc9;
        ext_e <= 8'h3c;
        repeat (4) @(posedge i_mclk);
        rd(gpx_pkg::ADDR_E_PIN, 8'h3c);
        rd(gpx_pkg::ADDR_F_PIN, 8'hc9);
        rd(gpx_pkg::ADDR_G_PIN, 8'h09);
        rd(gpx_pkg::ADDR_H_PIN, 8'hc9);
        chk(s_rdata, 8'h00);
        rd(gpx_pkg::ADDR_J_PIN, 8'h49);
        $display("test pin levels done");
        // Inputs with output bits set: pull-ups hold the undriven pads high.
        ext_en <= 8'h00;
        repeat (4) @(posedge i_mclk);
        #1;
        chk(pf_pu, 8'hff);
        chk(ph_pu, 8'hff);
        rd(gpx_pkg::ADDR_G_PIN, 8'h1f);
        wr(gpx_pkg::ADDR_MCU_CTRL, 8'hff);
        repeat (2) @(posedge i_mclk);
        #1;
        chk(pf_pu, 8'h00);
        chk(ph_pu, 8'h00);
        chk({3'h0, pg_pu}, 8'h00);
        chk({1'b0, pj_pu}, 8'h00);
        rd(gpx_pkg::ADDR_MCU_CTRL, 8'h10);
        wr(gpx_pkg::ADDR_MCU_CTRL, 8'h00);
        $display("test pull-up disable done");
        // Mixed directions: low nibble driven, high nibble from the board.
        wr(gpx_pkg::ADDR_F_DIR, 8'h0f);
        wr(gpx_pkg::ADDR_F_OUT, 8'ha5);
        ext_en <= 8'hf0;
        repeat (2) @(posedge i_mclk);
        #1;
        chk(pf_oe, 8'h0f);
        chk(pf_out, 8'ha5);
        chk(pf_pu, 8'ha0);
        repeat (2) @(posedge i_mclk);
        rd(gpx_pkg::ADDR_F_PIN, 8'hc5);
        rd(gpx_pkg::ADDR_F_OUT, 8'ha5);
        chk(s_rdata, 8'ha5);
        @(posedge i_mclk);
        #1;
        chk(o_rdata, 8'h00);
        $display("test mixed direction done");
        summarize();
    end

    // Watchdog: the sequence needs just over a hundred cycles.
    initial begin
        repeat (5000) @(posedge i_mclk);
        errors++;
        summarize();
    end
endmodule : gpx_top_tb_top
